// ---- xbar3_pkg.sv ----
// Constants for the third crossbar routing register.
// Assumes an SFR-style byte bus with address and page select.
package xbar3_pkg;
    localparam logic [7:0] XBAR3_ADDR = 8'hE4;
    localparam logic [7:0] XBAR3_PAGE = 8'h0F;
    localparam logic [7:0] XBAR3_RESET = 8'h00;
    localparam logic [7:0] XBAR3_WMASK = 8'h8F;
    localparam int BIT_TIMER_COUNT = 0;
    localparam int BIT_TIMER_TRIG = 1;
    localparam int BIT_CONV_START = 2;
    localparam int BIT_COMP_OUT = 3;
    localparam int BIT_CAN_DRIVE = 7;
    localparam int NUM_ROUTES = 4;
endpackage

// ---- route_gate.sv ----
// Gates one peripheral signal through the crossbar by an enable bit.
// Assumes the enable comes from a register in the same clock domain.
`timescale 1ns/1ps
module route_gate (
    // Control.
    input wire logic enable_in,
    // Signals.
    input wire logic sig_in,
    output logic sig_out
);
    // Pass the signal only while routed; otherwise hold it low.
    assign sig_out = enable_in & sig_in;
endmodule // route_gate

// ---- crossbar_routing_three.sv ----
// What this block does
// - Bit 3 set routes the comparator C output to its port pin, clear keeps it off every pin.
// - Bit 2 set routes the converter C convert-start input from its pin, clear leaves it unavailable.
// - Bit 1 set routes the timer C trigger input from its pin, clear disconnects it.
// - Bit 0 set routes the timer C count input from its pin, clear disconnects it.
// Crossbar register three with its four routes and the CAN drive select.
// Assumes a byte-wide SFR access port with page select, synchronous to core_clk_in.
// Assumes the pad logic outside turns can_tx_drive_select_out into the transmit pin's output style.
// Assumes the crossbar priority logic outside places each routed signal on its pin.
`timescale 1ns/1ps
module crossbar_routing_three (
    // Clock and reset.
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Register access port.
    input wire logic [7:0] sfr_addr_in,
    input wire logic [7:0] sfr_page_in,
    input wire logic sfr_wr_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    output logic sfr_sel_out,
    // Peripheral to pin.
    input wire logic comparator_c_output_in,
    output logic comparator_c_pin_out,
    // Pin to peripheral.
    input wire logic conv_c_start_pin_in,
    output logic conv_c_start_input_out,
    input wire logic timer_c_trigger_pin_in,
    output logic timer_c_trigger_input_out,
    input wire logic timer_c_count_pin_in,
    output logic timer_c_count_input_out,
    // CAN transmit pin drive style.
    output logic can_tx_drive_select_out
);
    // Stored register value; the registered read data is the only other state in the block.
    logic [7:0] crossbar_routing_three_reg;
    // Value the register takes at the next edge.
    logic [7:0] crossbar_routing_three_next;
    // High while the access port points at this register on its page.
    logic hit;
    // A write strobe that lands on this register.
    logic write_hit;
    // Register value as a read sees it, reserved bits forced low.
    logic [7:0] read_value;
    // Route enables, the low bits of the register.
    logic [xbar3_pkg::NUM_ROUTES-1:0] route_en;
    // Route sources and gated results, one bit per route in register bit order.
    logic [xbar3_pkg::NUM_ROUTES-1:0] route_src;
    logic [xbar3_pkg::NUM_ROUTES-1:0] route_dst;

    // Decode the register address on its page; the same address on another page is a different register.
    assign hit = (sfr_addr_in == xbar3_pkg::XBAR3_ADDR) && (sfr_page_in == xbar3_pkg::XBAR3_PAGE);
    assign write_hit = sfr_wr_in && hit;
    assign sfr_sel_out = hit;

    // Next value: a matched write loads the writable bits, anything else holds.
    // Masking here keeps the reserved bits zero in the stored value, so neither
    // the read path nor the outputs can ever see them.
    always_comb begin
        crossbar_routing_three_next = crossbar_routing_three_reg;
        if (write_hit) begin
            crossbar_routing_three_next = sfr_wdata_in & xbar3_pkg::XBAR3_WMASK;
        end
    end

    // Register update; reset wins over a write in the same cycle.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            crossbar_routing_three_reg <= xbar3_pkg::XBAR3_RESET;
        end else begin
            crossbar_routing_three_reg <= crossbar_routing_three_next;
        end
    end

    // Read value with the reserved bits cleared a second time, so a fault in the
    // write mask cannot put ones on the bus.
    assign read_value = crossbar_routing_three_reg & xbar3_pkg::XBAR3_WMASK;

    // Read data is registered and zero when not addressed; software sees the
    // value one cycle after the address and page match.
    always_ff @(posedge core_clk_in) begin
        if (!reset_n_in) begin
            sfr_rdata_out <= xbar3_pkg::XBAR3_RESET;
        end else begin
            sfr_rdata_out <= hit ? read_value : xbar3_pkg::XBAR3_RESET;
        end
    end

    // The route enables are the low bits of the register, bit 0 upward.
    assign route_en = crossbar_routing_three_reg[xbar3_pkg::NUM_ROUTES-1:0];

    // Gather the route sources in bit order. Directions are mixed on purpose:
    // bits 0 to 2 bring a pin in to a peripheral, bit 3 sends one out to a pin.
    assign route_src[xbar3_pkg::BIT_TIMER_COUNT] = timer_c_count_pin_in;
    assign route_src[xbar3_pkg::BIT_TIMER_TRIG] = timer_c_trigger_pin_in;
    assign route_src[xbar3_pkg::BIT_CONV_START] = conv_c_start_pin_in;
    assign route_src[xbar3_pkg::BIT_COMP_OUT] = comparator_c_output_in;

    // One gate per route, enabled by its register bit. An unrouted signal is
    // held low rather than left floating, so a cut-off timer input cannot count.
    genvar i;
    generate
        for (i = 0; i < xbar3_pkg::NUM_ROUTES; i++) begin : g_route
            route_gate u_gate (
                .enable_in(route_en[i]),
                .sig_in(route_src[i]),
                .sig_out(route_dst[i])
            );
        end
    endgenerate

    // Route outputs, named after the far end of each path.
    assign timer_c_count_input_out = route_dst[xbar3_pkg::BIT_TIMER_COUNT];
    assign timer_c_trigger_input_out = route_dst[xbar3_pkg::BIT_TIMER_TRIG];
    assign conv_c_start_input_out = route_dst[xbar3_pkg::BIT_CONV_START];
    assign comparator_c_pin_out = route_dst[xbar3_pkg::BIT_COMP_OUT];
    assign can_tx_drive_select_out = crossbar_routing_three_reg[xbar3_pkg::BIT_CAN_DRIVE];

    // Checks on the register and its routes. Properties that look one edge back
    // also require reset high at the first edge, since a reset landing at that
    // edge legitimately changes the register.

    // A matched write on the access port.
    sequence s_reg_write;
        reset_n_in && sfr_wr_in && hit;
    endsequence

    // A matched access that only reads.
    sequence s_reg_read;
        reset_n_in && hit && !sfr_wr_in;
    endsequence

    // A write aimed at some other address or page.
    sequence s_foreign_write;
        reset_n_in && sfr_wr_in && !hit;
    endsequence

    // An unrouted comparator output never reaches the pin, whatever the
    // comparator itself is doing.
    a_comp_gated: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        !crossbar_routing_three_reg[xbar3_pkg::BIT_COMP_OUT] |-> !comparator_c_pin_out)
        else $error("Comparator output reached pin while unrouted.");

    // A routed comparator output follows the comparator in the same cycle.
    a_comp_routed: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        crossbar_routing_three_reg[xbar3_pkg::BIT_COMP_OUT] |->
            comparator_c_pin_out == comparator_c_output_in)
        else $error("Routed comparator output does not follow the comparator.");

    // The convert-start input reaches the converter only while routed.
    a_conv_gated: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        conv_c_start_input_out ==
            (crossbar_routing_three_reg[xbar3_pkg::BIT_CONV_START] & conv_c_start_pin_in))
        else $error("Convert-start routing wrong.");

    // The trigger input reaches the timer only while routed.
    a_trig_gated: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        timer_c_trigger_input_out ==
            (crossbar_routing_three_reg[xbar3_pkg::BIT_TIMER_TRIG] & timer_c_trigger_pin_in))
        else $error("Timer trigger routing wrong.");

    // The count input reaches the timer only while routed.
    a_count_gated: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        timer_c_count_input_out ==
            (crossbar_routing_three_reg[xbar3_pkg::BIT_TIMER_COUNT] & timer_c_count_pin_in))
        else $error("Timer count routing wrong.");

    // A write sets the drive select from its top bit at the next edge.
    a_write_takes: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        s_reg_write |=> can_tx_drive_select_out == $past(sfr_wdata_in[xbar3_pkg::BIT_CAN_DRIVE]))
        else $error("Drive select did not follow write.");

    // A write sets the four route enables from its low bits at the next edge.
    a_write_routes: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        s_reg_write |=> route_en == $past(sfr_wdata_in[xbar3_pkg::NUM_ROUTES-1:0]))
        else $error("Route enables did not follow write.");

    // A write to another address or page leaves the register alone, so a
    // neighbouring register on another page cannot disturb the routes.
    a_foreign_ignored: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        s_foreign_write |=> $stable(crossbar_routing_three_reg))
        else $error("Register changed on a write to another address.");

    // Without a write the register holds its value.
    a_hold_idle: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (reset_n_in && !sfr_wr_in) |=> $stable(crossbar_routing_three_reg))
        else $error("Register changed without a write.");

    // Reserved bits read back as zero.
    a_reserved_zero: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (sfr_rdata_out & ~xbar3_pkg::XBAR3_WMASK) == 8'h00)
        else $error("Reserved bits read nonzero.");

    // Reserved bits are never stored either.
    a_reserved_unstored: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (crossbar_routing_three_reg & ~xbar3_pkg::XBAR3_WMASK) == 8'h00)
        else $error("Reserved bits stored nonzero.");

    // Reset clears the register whatever it held.
    a_reset_clear: assert property (@(posedge core_clk_in)
        !reset_n_in |=> crossbar_routing_three_reg == xbar3_pkg::XBAR3_RESET)
        else $error("Register not cleared by reset.");

    // Reset also clears the read data and selects open-drain drive.
    a_reset_outputs: assert property (@(posedge core_clk_in)
        !reset_n_in |=>
            (sfr_rdata_out == xbar3_pkg::XBAR3_RESET) && !can_tx_drive_select_out)
        else $error("Outputs not cleared by reset.");

    // A read returns the value that the register held when it was addressed.
    a_read_back: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        s_reg_read |=> sfr_rdata_out == $past(crossbar_routing_three_reg))
        else $error("Read data mismatch.");

    // Read data is zero while the register is not addressed, so several
    // registers can share one read bus by a plain OR.
    a_idle_read_zero: assert property (@(posedge core_clk_in) disable iff (!reset_n_in)
        (reset_n_in && !hit) |=> sfr_rdata_out == xbar3_pkg::XBAR3_RESET)
        else $error("Read data nonzero while not addressed.");
endmodule // crossbar_routing_three

// ---- crossbar_routing_three_test.sv ----
// Self-checking testbench for the third crossbar routing register.
// Assumes the design checks its own timing assertions inside its files.
`timescale 1ns/1ps
module crossbar_routing_three_test;
    logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, cmp_in = 1'b1, cnv_in = 1'b1, trg_in = 1'b1, cnt_in = 1'b1;
    logic [7:0] addr = xbar3_pkg::XBAR3_ADDR, page = xbar3_pkg::XBAR3_PAGE, wdata = 8'h00, rdata;
    logic sel, cmp_pin, cnv_out, trg_out, cnt_out, can_sel;
    int num_errors = 0, checks_done = 0, cycles = 0;
    crossbar_routing_three dut (.core_clk_in(clk), .reset_n_in(rst_n), .sfr_addr_in(addr), .sfr_page_in(page),
        .sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .sfr_sel_out(sel),
        .comparator_c_output_in(cmp_in), .comparator_c_pin_out(cmp_pin), .conv_c_start_pin_in(cnv_in),
        .conv_c_start_input_out(cnv_out), .timer_c_trigger_pin_in(trg_in), .timer_c_trigger_input_out(trg_out),
        .timer_c_count_pin_in(cnt_in), .timer_c_count_input_out(cnt_out), .can_tx_drive_select_out(can_sel));
    // Clock of 20 ns period; a hang is cut short after a fixed cycle budget.
    always #10 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (num_errors == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One write cycle, strobe held for exactly one edge.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
        @(posedge clk);
        addr <= a; page <= p; wr <= 1'b1; wdata <= d;
        @(posedge clk);
        wr <= 1'b0; addr <= xbar3_pkg::XBAR3_ADDR; page <= xbar3_pkg::XBAR3_PAGE;
    endtask
    // With all peripheral inputs high, each route output must mirror its enable bit.
    task automatic check_outs(input logic [7:0] v);
        @(posedge clk);
        #1;
        chk(cmp_pin, v[3]);
        chk(cnv_out, v[2]);
        chk(trg_out, v[1]);
        chk(cnt_out, v[0]);
        chk(can_sel, v[7]);
        chk(rdata, v & 8'h8F);
        chk(sel, 1'b1);
    endtask
    task automatic t_reset();
        check_outs(8'h00);
    endtask
    task automatic t_single_bits();
        for (int i = 0; i < 4; i++) begin
            wr_reg(xbar3_pkg::XBAR3_ADDR, xbar3_pkg::XBAR3_PAGE, 8'h01 << i);
            check_outs(8'h01 << i);
        end
    endtask
    // Reserved bits are dropped, then foreign page and address writes are ignored.
    task automatic t_reserved_refused();
        wr_reg(xbar3_pkg::XBAR3_ADDR, xbar3_pkg::XBAR3_PAGE, 8'hFF);
        check_outs(8'h8F);
        wr_reg(xbar3_pkg::XBAR3_ADDR, 8'h00, 8'h00);
        wr_reg(8'hE3, xbar3_pkg::XBAR3_PAGE, 8'h00);
        check_outs(8'h8F);
        @(posedge clk);
        cmp_in <= 1'b0; cnv_in <= 1'b0; trg_in <= 1'b0; cnt_in <= 1'b0; addr <= 8'hE5;
        @(posedge clk);
        @(posedge clk);
        #1;
        chk({cmp_pin, cnv_out, trg_out, cnt_out}, 4'h0);
        chk(rdata, 8'h00);
        chk(sel, 1'b0);
    endtask
    // A reset in mid-run clears a loaded register, and the first write after release lands.
    task automatic t_mid_reset();
        @(posedge clk);
        rst_n <= 1'b0; addr <= xbar3_pkg::XBAR3_ADDR;
        cmp_in <= 1'b1; cnv_in <= 1'b1; trg_in <= 1'b1; cnt_in <= 1'b1;
        @(posedge clk);
        rst_n <= 1'b1;
        check_outs(8'h00);
        wr_reg(xbar3_pkg::XBAR3_ADDR, xbar3_pkg::XBAR3_PAGE, 8'h81);
        check_outs(8'h81);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_single_bits();
        t_reserved_refused();
        t_mid_reset();
        end_sim();
    end
endmodule // crossbar_routing_three_test
